// >>> ctu_pkg.sv
/*
 Package for the cascaded timer pair: register offsets, control field
 positions, reset values and clock source codes.
 Assumes a 32-bit APB register bus and a single core clock.
*/
`default_nettype none

package ctu_pkg;

   localparam int unsigned CNT_W = 16;
   localparam int unsigned CTL_W = 8;
   localparam int unsigned PSC_W = 3;
   localparam int unsigned PDIV_W = 7;

   localparam logic [7:0] OFS_T1_CTL = 8'h00;
   localparam logic [7:0] OFS_T2_CTL = 8'h04;
   localparam logic [7:0] OFS_T1_CNT = 8'h08;
   localparam logic [7:0] OFS_T2_CNT = 8'h0c;
   localparam logic [7:0] OFS_CH_CTL = 8'h10;
   localparam logic [7:0] OFS_TIME32 = 8'h14;

   localparam int unsigned BIT_CASCADE = 7;
   localparam int unsigned BIT_ENABLE = 6;
   localparam int unsigned BIT_DIR = 5;
   localparam int unsigned SRC_HI = 4;
   localparam int unsigned SRC_LO = 3;
   localparam int unsigned PSC_HI = 2;
   localparam int unsigned PSC_LO = 0;
   localparam int unsigned BIT_CHAIN = 0;

   localparam logic [1:0] SRC_CORE = 2'h0;
   localparam logic [1:0] SRC_EXT = 2'h1;

   localparam logic [CTL_W-1:0] CTL_RST = 8'h00;
   localparam logic [CTL_W-1:0] CH_RST = 8'h00;
   localparam logic [CTL_W-1:0] T1_CTL_MASK = 8'h7f;
   localparam logic [CTL_W-1:0] CH_CTL_MASK = 8'hfe;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;

endpackage

`default_nettype wire

// >>> ctu_tmr_if.sv
/*
 Carrier between the register block and one timer unit.
 Assumes both ends run on the core clock.
*/
`timescale 1ns/10ps
`default_nettype none

interface ctu_tmr_if;
   logic                       enable;
   logic                       up;
   logic                       src_tick;
   logic [ctu_pkg::PSC_W-1:0]  presc;
   logic                       use_bypass;
   logic                       bypass_tick;
   logic                       load;
   logic [ctu_pkg::CNT_W-1:0]  load_val;
   logic [ctu_pkg::CNT_W-1:0]  count;
   logic                       ovf;
   logic                       presc_tick;

   modport unit (input enable, up, src_tick, presc, use_bypass, bypass_tick, load, load_val,
                 output count, ovf, presc_tick);
   modport ctrl (output enable, up, src_tick, presc, use_bypass, bypass_tick, load, load_val,
                 input count, ovf, presc_tick);
endinterface

`default_nettype wire

// >>> ctu_timer_unit.sv
/*
 One 16-bit timer: prescaler, clock selector between prescaler and bypass
 tick, and an up/down counter with a load port.
 Assumes the source tick is a one-cycle enable pulse on the core clock.
*/
`timescale 1ns/10ps
`default_nettype none

module ctu_timer_unit
(
   input  wire logic  core_clk_i,
   input  wire logic  rst_n_i,
   ctu_tmr_if.unit    tif
);

   logic [ctu_pkg::PDIV_W-1:0] pdiv_reg;
   logic [ctu_pkg::PDIV_W-1:0] pdiv_next;
   logic [ctu_pkg::CNT_W-1:0]  count_reg;
   logic [ctu_pkg::CNT_W-1:0]  count_next;
   logic [ctu_pkg::PDIV_W-1:0] pdiv_last;
   logic                       step;

   always_comb
   begin
      pdiv_last = (ctu_pkg::PDIV_W'(1) << tif.presc) - ctu_pkg::PDIV_W'(1);
      tif.presc_tick = tif.src_tick && (pdiv_reg >= pdiv_last); // RQ3
      pdiv_next = pdiv_reg;
      if (!tif.enable || tif.presc_tick)
      begin
         pdiv_next = '0;
      end
      else if (tif.src_tick)
      begin
         pdiv_next = pdiv_reg + ctu_pkg::PDIV_W'(1);
      end
      // The bypass path skips the prescaler entirely, so a cascaded timer moves once per carry.
      step = tif.enable && (tif.use_bypass ? tif.bypass_tick : tif.presc_tick); // RQ2 RQ3 RQ6
      tif.ovf = step && !tif.load && (tif.up ? (count_reg == ctu_pkg::CNT_MAX)
                                             : (count_reg == ctu_pkg::CNT_RST));
      count_next = count_reg;
      if (tif.load)
      begin
         count_next = tif.load_val;
      end
      else if (step)
      begin
         count_next = tif.up ? count_reg + ctu_pkg::CNT_W'(1) : count_reg - ctu_pkg::CNT_W'(1);
      end
      tif.count = count_reg;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         pdiv_reg <= '0;
         count_reg <= ctu_pkg::CNT_RST;
      end
      else
      begin
         pdiv_reg <= pdiv_next;
         count_reg <= count_next;
      end
   end

endmodule

`default_nettype wire

// >>> ctu_cascaded_timer.sv
/*
 Cascaded timer pair with an APB register slave: two 16-bit timers that
 can be joined into one 32-bit time base, plus a channel control register.
 Assumes APB signals synchronous to core_clk_i and external ticks that are
 one-cycle pulses already synchronous to the same clock.
*/
// How it works
// RQ1 - With cascade bit 7 set, timer 1 direction bit steers both timers.
// RQ2 - With cascade set, timer 1 overflow clocks timer 2, skipping its prescaler.
// RQ3 - Source select bits 4:3 feed prescaler; prescaler or overflow chosen by cascade bit.
// RQ4 - Channel control bit 0 has no chaining effect; software writes it zero.
// RQ5 - Only the timer pair forms 32 bits; channels are never joined.
// RQ6 - Cascade clear: each timer uses its own direction and prescaled clock.
`timescale 1ns/10ps
`default_nettype none

module ctu_cascaded_timer
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [1:0]  ext_tick_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             timer2_overflow_o
);

   ctu_tmr_if t1_if ();
   ctu_tmr_if t2_if ();

   logic [ctu_pkg::CTL_W-1:0] timer1_control_reg;
   logic [ctu_pkg::CTL_W-1:0] timer1_control_next;
   logic [ctu_pkg::CTL_W-1:0] timer2_control_reg;
   logic [ctu_pkg::CTL_W-1:0] timer2_control_next;
   logic [ctu_pkg::CTL_W-1:0] channel_control_reg;
   logic [ctu_pkg::CTL_W-1:0] channel_control_next;
   logic [31:0]               prdata_reg;
   logic [31:0]               prdata_next;
   logic                      pready_reg;
   logic                      pready_next;
   logic                      pslverr_reg;
   logic                      pslverr_next;
   logic                      t2ovf_reg;
   logic                      t2ovf_next;
   logic                      wr_en;
   logic                      cascade;
   logic [31:0]               rd_word;
   logic                      rd_hit;

   function automatic logic src_tick_of(input logic [1:0] sel, input logic ext);
      src_tick_of = (sel == ctu_pkg::SRC_CORE) || ((sel == ctu_pkg::SRC_EXT) && ext);
   endfunction

   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == ctu_pkg::OFS_T1_CTL) || (a == ctu_pkg::OFS_T2_CTL) ||
                   (a == ctu_pkg::OFS_T1_CNT) || (a == ctu_pkg::OFS_T2_CNT) ||
                   (a == ctu_pkg::OFS_CH_CTL) || (a == ctu_pkg::OFS_TIME32);
   endfunction

   assign cascade = timer2_control_reg[ctu_pkg::BIT_CASCADE];
   assign wr_en = psel_i && penable_i && pready_reg && pwrite_i && addr_known(paddr_i);

   // Timer control hookup.
   always_comb
   begin
      t1_if.enable = timer1_control_reg[ctu_pkg::BIT_ENABLE];
      t1_if.up = timer1_control_reg[ctu_pkg::BIT_DIR];
      t1_if.presc = timer1_control_reg[ctu_pkg::PSC_HI:ctu_pkg::PSC_LO];
      t1_if.src_tick = src_tick_of(timer1_control_reg[ctu_pkg::SRC_HI:ctu_pkg::SRC_LO], ext_tick_i[0]);
      t1_if.use_bypass = 1'b0;
      t1_if.bypass_tick = 1'b0;
      t1_if.load = wr_en && (paddr_i == ctu_pkg::OFS_T1_CNT);
      t1_if.load_val = pwdata_i[ctu_pkg::CNT_W-1:0];
      t2_if.enable = timer2_control_reg[ctu_pkg::BIT_ENABLE];
      // With cascade set, timer 1's direction bit rules both halves so the 32-bit value never tears.
      t2_if.up = cascade ? timer1_control_reg[ctu_pkg::BIT_DIR]
                         : timer2_control_reg[ctu_pkg::BIT_DIR]; // RQ1 RQ6
      t2_if.presc = timer2_control_reg[ctu_pkg::PSC_HI:ctu_pkg::PSC_LO];
      t2_if.src_tick = src_tick_of(timer2_control_reg[ctu_pkg::SRC_HI:ctu_pkg::SRC_LO],
                                   ext_tick_i[1]); // RQ3
      t2_if.use_bypass = cascade; // RQ2
      t2_if.bypass_tick = t1_if.ovf; // RQ2
      t2_if.load = wr_en && (paddr_i == ctu_pkg::OFS_T2_CNT);
      t2_if.load_val = pwdata_i[ctu_pkg::CNT_W-1:0];
   end

   ctu_timer_unit u_timer1
   (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .tif        (t1_if.unit)
   );

   ctu_timer_unit u_timer2
   (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .tif        (t2_if.unit)
   );

   // Register read mux.
   always_comb
   begin
      rd_hit = 1'b1;
      rd_word = 32'h0000_0000;
      unique case (paddr_i)
         ctu_pkg::OFS_T1_CTL: rd_word[ctu_pkg::CTL_W-1:0] = timer1_control_reg;
         ctu_pkg::OFS_T2_CTL: rd_word[ctu_pkg::CTL_W-1:0] = timer2_control_reg;
         ctu_pkg::OFS_T1_CNT: rd_word[ctu_pkg::CNT_W-1:0] = t1_if.count;
         ctu_pkg::OFS_T2_CNT: rd_word[ctu_pkg::CNT_W-1:0] = t2_if.count;
         ctu_pkg::OFS_CH_CTL: rd_word[ctu_pkg::CTL_W-1:0] = channel_control_reg; // RQ4
         // The only 32-bit value is the timer pair; channels have no joined form.
         ctu_pkg::OFS_TIME32: rd_word = {t2_if.count, t1_if.count}; // RQ5
         default: rd_hit = 1'b0;
      endcase
   end

   // Bus and register next state.
   always_comb
   begin
      timer1_control_next = timer1_control_reg;
      timer2_control_next = timer2_control_reg;
      channel_control_next = channel_control_reg;
      prdata_next = prdata_reg;
      pslverr_next = 1'b0;
      // The answer is prepared in the setup cycle, so every access ends at its first access edge.
      pready_next = psel_i && !penable_i;
      if (psel_i && !penable_i)
      begin
         prdata_next = (rd_hit && !pwrite_i) ? rd_word : 32'h0000_0000;
         pslverr_next = !rd_hit;
      end
      else if (psel_i && penable_i && pready_reg)
      begin
         pslverr_next = 1'b0;
      end
      else
      begin
         pslverr_next = pslverr_reg;
      end
      if (wr_en && paddr_i == ctu_pkg::OFS_T1_CTL)
      begin
         timer1_control_next = pwdata_i[ctu_pkg::CTL_W-1:0] & ctu_pkg::T1_CTL_MASK;
      end
      if (wr_en && paddr_i == ctu_pkg::OFS_T2_CTL)
      begin
         timer2_control_next = pwdata_i[ctu_pkg::CTL_W-1:0];
      end
      if (wr_en && paddr_i == ctu_pkg::OFS_CH_CTL)
      begin
         // The chain bit is dropped: joining adjacent channels is not built.
         channel_control_next = pwdata_i[ctu_pkg::CTL_W-1:0] & ctu_pkg::CH_CTL_MASK; // RQ4 RQ5
      end
      t2ovf_next = t2_if.ovf;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         timer1_control_reg <= ctu_pkg::CTL_RST;
         timer2_control_reg <= ctu_pkg::CTL_RST;
         channel_control_reg <= ctu_pkg::CH_RST;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         t2ovf_reg <= 1'b0;
      end
      else
      begin
         timer1_control_reg <= timer1_control_next;
         timer2_control_reg <= timer2_control_next;
         channel_control_reg <= channel_control_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         t2ovf_reg <= t2ovf_next;
      end
   end

   assign prdata_o = prdata_reg;
   assign pready_o = pready_reg;
   assign pslverr_o = pslverr_reg;
   assign timer2_overflow_o = t2ovf_reg;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   cascade_dir_a: assert property ( // RQ1
      (cascade && t2_if.enable && t1_if.ovf && !t2_if.load && timer1_control_reg[ctu_pkg::BIT_DIR])
      |=> (t2_if.count == $past(t2_if.count) + 16'h0001))
      else $error("cascaded timer 2 did not follow timer 1 direction");

   cascade_clock_a: assert property ( // RQ2
      ($past(cascade) && !$past(t2_if.load) && $changed(t2_if.count)) |-> $past(t1_if.ovf))
      else $error("cascaded timer 2 moved without timer 1 overflow");

   cascade_bypass_a: assert property ( // RQ2
      (cascade && t2_if.enable && t1_if.ovf && !t2_if.load) |=> $changed(t2_if.count))
      else $error("timer 1 overflow did not clock timer 2");

   own_clock_a: assert property ( // RQ3
      (!$past(cascade) && !$past(t2_if.load) && $changed(t2_if.count)) |-> $past(t2_if.presc_tick))
      else $error("timer 2 moved without its prescaler tick");

   chain_bit_a: assert property ( // RQ4
      channel_control_reg[ctu_pkg::BIT_CHAIN] == 1'b0)
      else $error("channel chain bit took a value");

   time_word_a: assert property ( // RQ5
      (psel_i && !penable_i && !pwrite_i && paddr_i == ctu_pkg::OFS_TIME32)
      |=> (prdata_o == {$past(t2_if.count), $past(t1_if.count)}))
      else $error("32-bit time read does not match timer pair");

   own_dir_a: assert property ( // RQ6
      (!cascade && t2_if.enable && t2_if.presc_tick && !t2_if.load && !timer2_control_reg[ctu_pkg::BIT_DIR])
      |=> (t2_if.count == $past(t2_if.count) - 16'h0001))
      else $error("timer 2 ignored its own direction bit");

   apb_answer_a: assert property (
      (psel_i && !penable_i) |=> pready_o)
      else $error("setup cycle not answered at the next edge");

   ready_pulse_a: assert property (
      pready_o |=> !pready_o)
      else $error("ready stood for more than one cycle");

   unmapped_error_a: assert property (
      (psel_i && !penable_i && !addr_known(paddr_i)) |=> (pready_o && pslverr_o))
      else $error("unmapped access not answered with an error");

   mapped_no_error_a: assert property (
      (psel_i && !penable_i && addr_known(paddr_i)) |=> (pready_o && !pslverr_o))
      else $error("mapped access answered with an error");

   unmapped_zero_a: assert property (
      (psel_i && !penable_i && !addr_known(paddr_i)) |=> (prdata_o == 32'h0000_0000))
      else $error("unmapped access returned nonzero data");

   write_zero_a: assert property (
      (psel_i && !penable_i && pwrite_i) |=> (prdata_o == 32'h0000_0000))
      else $error("write access returned nonzero data");

   overflow_out_a: assert property (
      t2_if.ovf |=> timer2_overflow_o)
      else $error("timer 2 wrap not shown on the overflow output");

   overflow_quiet_a: assert property (
      !t2_if.ovf |=> !timer2_overflow_o)
      else $error("overflow output high without a timer 2 wrap");

   load_t1_a: assert property (
      t1_if.load |=> (t1_if.count == $past(t1_if.load_val)))
      else $error("timer 1 count did not take the loaded value");

   load_t2_a: assert property (
      t2_if.load |=> (t2_if.count == $past(t2_if.load_val)))
      else $error("timer 2 count did not take the loaded value");

   hold_t1_a: assert property (
      (!t1_if.enable && !t1_if.load) |=> $stable(t1_if.count))
      else $error("disabled timer 1 moved");

   hold_t2_a: assert property (
      (!t2_if.enable && !t2_if.load) |=> $stable(t2_if.count))
      else $error("disabled timer 2 moved");

   t1_up_a: assert property ( // RQ6
      (t1_if.enable && t1_if.presc_tick && !t1_if.load && timer1_control_reg[ctu_pkg::BIT_DIR])
      |=> (t1_if.count == $past(t1_if.count) + 16'h0001))
      else $error("timer 1 did not count up on its own direction bit");

   t1_down_a: assert property ( // RQ1
      (t1_if.enable && t1_if.presc_tick && !t1_if.load && !timer1_control_reg[ctu_pkg::BIT_DIR])
      |=> (t1_if.count == $past(t1_if.count) - 16'h0001))
      else $error("timer 1 did not count down on its own direction bit");

   cascade_down_a: assert property ( // RQ1
      (cascade && t2_if.enable && t1_if.ovf && !t2_if.load && !timer1_control_reg[ctu_pkg::BIT_DIR])
      |=> (t2_if.count == $past(t2_if.count) - 16'h0001))
      else $error("cascaded timer 2 did not count down with timer 1");

   cascade_hold_a: assert property ( // RQ2
      (cascade && !t1_if.ovf && !t2_if.load) |=> $stable(t2_if.count))
      else $error("cascaded timer 2 moved on its own clock");

   presc_gate_a: assert property ( // RQ3
      (!cascade && !t2_if.presc_tick && !t2_if.load) |=> $stable(t2_if.count))
      else $error("split timer 2 moved without a prescaler tick");

   no_source_a: assert property ( // RQ3
      (timer2_control_reg[ctu_pkg::SRC_HI:ctu_pkg::SRC_LO] != ctu_pkg::SRC_CORE &&
       timer2_control_reg[ctu_pkg::SRC_HI:ctu_pkg::SRC_LO] != ctu_pkg::SRC_EXT) |-> !t2_if.presc_tick)
      else $error("timer 2 prescaler ticked with no source selected");

   t1_cascade_zero_a: assert property (
      !timer1_control_reg[ctu_pkg::BIT_CASCADE])
      else $error("timer 1 control kept a cascade bit");

endmodule

`default_nettype wire

// >>> cascaded_timer_pair_bench.sv
/*
 Self-checking bench for the cascaded timer pair: APB accesses, external
 ticks and comparisons of counts against values worked out by hand.
 Assumes ctu_pkg, ctu_tmr_if and the design modules are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module cascaded_timer_pair_bench;
   logic        core_clk_i;
   logic        rst_n_i;
   logic        psel_i;
   logic        penable_i;
   logic        pwrite_i;
   logic [7:0]  paddr_i;
   logic [31:0] pwdata_i;
   logic [1:0]  ext_tick_i;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   logic        timer2_overflow_o;
   logic [31:0] rd;
   logic        er;
   int          err_total;
   int          n_checks;
   int          ovf_seen = 0;
   int          cyc = 0;
   int          c0;

   ctu_cascaded_timer u_dut
   (
      .core_clk_i        (core_clk_i),
      .rst_n_i           (rst_n_i),
      .psel_i            (psel_i),
      .penable_i         (penable_i),
      .pwrite_i          (pwrite_i),
      .paddr_i           (paddr_i),
      .pwdata_i          (pwdata_i),
      .ext_tick_i        (ext_tick_i),
      .prdata_o          (prdata_o),
      .pready_o          (pready_o),
      .pslverr_o         (pslverr_o),
      .timer2_overflow_o (timer2_overflow_o)
   );

   always #5 core_clk_i = ~core_clk_i;

   always @(posedge core_clk_i)
   begin
      if (timer2_overflow_o === 1'b1)
      begin
         ovf_seen <= ovf_seen + 1;
      end
   end

   always @(posedge core_clk_i)
   begin
      cyc <= cyc + 1;
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
      begin
         $display("DONE - PASS");
      end
      else
      begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // The request is held until pready is sampled high; after 20 access edges without it the test stops as failed.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      do
      begin
         @(posedge core_clk_i);
         n++;
      end
      while (pready_o !== 1'b1 && n < 20);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (pready_o !== 1'b1)
      begin
         err_total++;
         $display("CHECK FAILED apb ready expected 1 seen timeout");
         stop_test();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      check("write error flag", {31'h0, er}, 32'h0);
   endtask

   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(what, rd, exp);
   endtask

   task automatic tick(input logic [1:0] m, input int k);
      repeat (k)
      begin
         @(posedge core_clk_i);
         ext_tick_i <= m;
         @(posedge core_clk_i);
         ext_tick_i <= 2'h0;
      end
      repeat (2) @(posedge core_clk_i);
   endtask

   initial
   begin
      repeat (20000) @(posedge core_clk_i);
      err_total++;
      $display("CHECK FAILED run length expected end seen timeout");
      stop_test();
   end

   initial
   begin
      core_clk_i = 1'b0;
      rst_n_i = 1'b0;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 8'h00;
      pwdata_i = 32'h0;
      ext_tick_i = 2'h0;
      err_total = 0;
      n_checks = 0;
      repeat (5) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         rchk("reset value", 8'(i * 4), 32'h0);
      end
      wr(ctu_pkg::OFS_T1_CTL, 32'hff);
      rchk("timer1 control", ctu_pkg::OFS_T1_CTL, 32'h7f);
      wr(ctu_pkg::OFS_T1_CTL, 32'h0);
      wr(ctu_pkg::OFS_CH_CTL, 32'hfe);
      rchk("channel control", ctu_pkg::OFS_CH_CTL, 32'hfe);
      apb(1'b1, 8'h18, 32'h1);
      check("unmapped error", {31'h0, er}, 32'h1);
      wr(ctu_pkg::OFS_TIME32, 32'h12345678);
      rchk("time value read only", ctu_pkg::OFS_TIME32, 32'h0);
      $display("test registers done");
      // Both timers on external ticks, so every count step is commanded here.
      wr(ctu_pkg::OFS_T1_CNT, 32'h10);
      wr(ctu_pkg::OFS_T2_CNT, 32'h10);
      wr(ctu_pkg::OFS_T1_CTL, 32'h68);
      wr(ctu_pkg::OFS_T2_CTL, 32'h48);
      tick(2'h3, 3);
      rchk("split time", ctu_pkg::OFS_TIME32, 32'h000d0013);
      wr(ctu_pkg::OFS_T2_CTL, 32'h49);
      tick(2'h2, 4);
      rchk("prescaled timer2", ctu_pkg::OFS_T2_CNT, 32'h0b);
      wr(ctu_pkg::OFS_T2_CTL, 32'h50);
      tick(2'h2, 2);
      rchk("unclocked timer2", ctu_pkg::OFS_T2_CNT, 32'h0b);
      wr(ctu_pkg::OFS_T1_CTL, 32'h0);
      tick(2'h1, 2);
      rchk("disabled timer1", ctu_pkg::OFS_T1_CNT, 32'h13);
      // Core clock source: timer 1 steps on every edge after the enabling write up to the disabling one.
      wr(ctu_pkg::OFS_T1_CNT, 32'h0);
      wr(ctu_pkg::OFS_T1_CTL, 32'h60);
      c0 = cyc;
      wr(ctu_pkg::OFS_T1_CTL, 32'h0);
      rchk("core clock timer1", ctu_pkg::OFS_T1_CNT, 32'(cyc - c0));
      $display("test split timers done");
      // Timer 2 has no source and the longest prescale, so only the bypass can move it.
      wr(ctu_pkg::OFS_T1_CNT, 32'hfffe);
      wr(ctu_pkg::OFS_T2_CNT, 32'hffff);
      wr(ctu_pkg::OFS_T2_CTL, 32'hd7);
      wr(ctu_pkg::OFS_T1_CTL, 32'h68);
      tick(2'h3, 2);
      rchk("cascade up", ctu_pkg::OFS_TIME32, 32'h0);
      check("overflow pulses", 32'(ovf_seen), 32'h1);
      wr(ctu_pkg::OFS_T2_CNT, 32'h5);
      wr(ctu_pkg::OFS_T2_CTL, 32'hf7);
      wr(ctu_pkg::OFS_T1_CTL, 32'h48);
      tick(2'h3, 1);
      rchk("cascade down", ctu_pkg::OFS_TIME32, 32'h0004ffff);
      check("overflow pulses", 32'(ovf_seen), 32'h1);
      $display("test cascade done");
      stop_test();
   end
endmodule

`default_nettype wire
